// ---- ipp_pkg.sv ----
/*
 * Shared constants for the interrupt positioning pulser: register map,
 * control and status bit positions, reset values, source codes and timing.
 * Assumes a single 10 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package ipp_pkg;

    // System clock
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 100;

    // Register byte addresses
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_SOURCE = 5'h04;
    localparam logic [4:0] ADDR_COUNT = 5'h08;
    localparam logic [4:0] ADDR_FREQ = 5'h0C;
    localparam logic [4:0] ADDR_RAMP = 5'h10;
    localparam logic [4:0] ADDR_STATUS = 5'h14;
    localparam logic [4:0] ADDR_POSITION = 5'h18;

    // Control register bits
    localparam int CTRL_START = 0;
    localparam int CTRL_SOFT_TRIGGER = 1;
    localparam int CTRL_IRQ_INVERT = 2;
    localparam int CTRL_SELECT_ENABLE = 3;
    localparam int CTRL_FWD_LIMIT = 4;
    localparam int CTRL_REV_LIMIT = 5;
    localparam int CTRL_WIDTH = 6;

    // Status register bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_COMPLETE = 1;
    localparam int STAT_ABNORMAL = 2;
    localparam int STAT_OP_ERROR = 3;
    localparam int STAT_REFUSED = 4;
    localparam int STAT_DIRECTION = 5;

    // Reset values
    localparam logic [31:0] RESET_CTRL = 32'h0000_0000;
    localparam logic [3:0] RESET_SOURCE = 4'h0;
    localparam logic [31:0] RESET_COUNT = 32'h0000_0000;
    localparam logic [31:0] RESET_FREQ = 32'h0000_03E8;
    localparam logic [15:0] RESET_RAMP = 16'h0000;

    // Interrupt source selection codes
    localparam logic [3:0] SRC_LAST_INPUT = 4'h7;
    localparam logic [3:0] SRC_SOFT = 4'h8;
    localparam logic [3:0] SRC_UNUSED = 4'hF;
    localparam logic [2:0] DEFAULT_INPUT = 3'd0;

    // Pulse total at which a move that never saw its interrupt gives up
    localparam logic [32:0] PULSE_OVERFLOW = 33'h1_0000_0000;

    typedef enum logic [3:0] {
        IPP_IDLE = 4'b0001,
        IPP_RUN = 4'b0010,
        IPP_POSIT = 4'b0100,
        IPP_STOP = 4'b1000
    } ipp_state_t;

endpackage : ipp_pkg

// ---- ipp_rate_gen.sv ----
/*
 * Square-wave pulse generator driven by a phase accumulator.
 * Assumes freq is well below half the system clock; a rising edge of
 * pulseOut is flagged by a one-cycle tick.
 */
module ipp_rate_gen
    import ipp_pkg::*;
#(
    parameter int FREQ_WIDTH = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [FREQ_WIDTH-1:0] freq,
    output logic pulseOut,
    output logic tick
);

    localparam logic [FREQ_WIDTH:0] WRAP = (FREQ_WIDTH + 1)'(CLK_HZ);

    logic [FREQ_WIDTH:0] acc_reg;
    logic [FREQ_WIDTH+1:0] sum;

    // Two half periods per pulse, so the accumulator advances at twice freq
    assign sum = {1'b0, acc_reg} + {freq, 1'b0};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_reg <= '0;
            pulseOut <= 1'b0;
            tick <= 1'b0;
        end else if (!enable) begin
            acc_reg <= '0;
            pulseOut <= 1'b0;
            tick <= 1'b0;
        end else if (sum >= {1'b0, WRAP}) begin
            acc_reg <= (FREQ_WIDTH + 1)'(sum - {1'b0, WRAP});
            pulseOut <= !pulseOut;
            tick <= !pulseOut;
        end else begin
            acc_reg <= sum[FREQ_WIDTH:0];
            tick <= 1'b0;
        end
    end

endmodule : ipp_rate_gen

// ---- ipp_positioner.sv ----
/*
 * One interrupt positioning pulse channel with its Avalon-MM register file.
 * Assumes the interrupt inputs are synchronous to clk and that the motor
 * drive takes one pulse per rising edge of pulseOut, direction from
 * directionOut.
 */
// The Avalon-MM slave port and the address map are this design's own decisions.
// Overview of operation
// R01: Soft trigger source emits count then stops
// R02: Software clears soft trigger before restarting
// R03: Polarity bit chooses high or low assertion
// R04: Polarity ignored for soft trigger source
// R05: Direction from count sign, programmed frequency
// R06: After interrupt, emit count then stop
// R07: Normal completion sets complete flag
// R08: Lower frequency so deceleration fits count
// R09: Count should cover acceleration plus deceleration
// R10: Interrupt already asserted gives plain relative move
// R11: Operands latched at start, changes ignored
// R12: Start removed: decelerate, complete stays clear
// R13: Pulse overflow before interrupt: stop, complete
// R14: Refuse new start while busy
// R15: Software waits for busy clear
// R16: Limit in travel direction: decelerate, abnormal
// R17: Chosen interrupt input claimed from other uses
// R18: Nibble selects input, soft trigger, unused
// R19: Nibble nine to E: error, no motion
// R20: Forward pulses increment, reverse decrement position
// R21: Synchronise, polarise, detect asserting edge
module ipp_positioner
    import ipp_pkg::*;
#(
    parameter int NUM_INPUTS = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [4:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    input wire logic [NUM_INPUTS-1:0] interruptInput,
    output logic pulseOutput,
    output logic directionOutput,
    output logic [NUM_INPUTS-1:0] irqClaim,
    output logic busy
);

    function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] be);
        logic [31:0] result;
        result = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                result[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return result;
    endfunction : byteMerge

    function automatic logic [31:0] rampStepOf(input logic [15:0] ramp, input logic [31:0] target);
        return (ramp == 16'h0000) ? target : {16'h0000, ramp};
    endfunction : rampStepOf

    // Bus slave
    logic ack_reg;
    logic writeAccept;
    logic [CTRL_WIDTH-1:0] ctrl_reg;
    logic [3:0] source_reg;
    logic [31:0] count_reg;
    logic [31:0] freq_reg;
    logic [15:0] ramp_reg;

    // Channel state
    ipp_state_t state_reg;
    logic [3:0] latchSource_reg;
    logic [31:0] latchTarget_reg;
    logic [31:0] latchStep_reg;
    logic [31:0] remaining_reg;
    logic [32:0] pulseTotal_reg;
    logic [31:0] curFreq_reg;
    logic dir_reg;
    logic abortAbnormal_reg;
    logic complete_reg;
    logic abnormal_reg;
    logic opError_reg;
    logic refused_reg;
    logic [31:0] position_reg;
    logic startPrev_reg;
    logic [NUM_INPUTS-1:0] irqMeta_reg;
    logic [NUM_INPUTS-1:0] irqSync_reg;
    logic irqLevelPrev_reg;

    logic tick;
    logic startCmd;
    logic startRise;
    logic [3:0] liveSource;
    logic [3:0] activeSource;
    logic selectedRaw;
    logic irqLevel;
    logic irqEdge;
    logic sourceBad;
    logic limitHit;
    logic [31:0] absCount;
    logic [47:0] fitFreq;
    logic [31:0] nextStop;

    assign writeAccept = avsWrite && ack_reg;
    assign avsWaitrequest = (avsRead || avsWrite) && !ack_reg;

    // One wait cycle per access; readdata is loaded during it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avsRead || avsWrite) && !ack_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avsReaddata <= 32'h0000_0000;
        end else if (avsRead && !ack_reg) begin
            unique case (avsAddress)
                ADDR_CTRL: avsReaddata <= {26'h00_0000, ctrl_reg};
                ADDR_SOURCE: avsReaddata <= {28'h000_0000, source_reg};
                ADDR_COUNT: avsReaddata <= count_reg;
                ADDR_FREQ: avsReaddata <= freq_reg;
                ADDR_RAMP: avsReaddata <= {16'h0000, ramp_reg};
                ADDR_STATUS: avsReaddata <= {26'h00_0000, dir_reg, refused_reg, opError_reg,
                                             abnormal_reg, complete_reg, busy};
                ADDR_POSITION: avsReaddata <= position_reg;
                default: avsReaddata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= RESET_CTRL[CTRL_WIDTH-1:0];
            source_reg <= RESET_SOURCE;
            count_reg <= RESET_COUNT;
            freq_reg <= RESET_FREQ;
            ramp_reg <= RESET_RAMP;
        end else if (writeAccept) begin
            unique case (avsAddress)
                ADDR_CTRL: ctrl_reg <= CTRL_WIDTH'(byteMerge({26'h00_0000, ctrl_reg}, avsWritedata,
                                                             avsByteenable));
                ADDR_SOURCE: source_reg <= 4'(byteMerge({28'h000_0000, source_reg}, avsWritedata,
                                                        avsByteenable));
                ADDR_COUNT: count_reg <= byteMerge(count_reg, avsWritedata, avsByteenable);
                ADDR_FREQ: freq_reg <= byteMerge(freq_reg, avsWritedata, avsByteenable);
                ADDR_RAMP: ramp_reg <= 16'(byteMerge({16'h0000, ramp_reg}, avsWritedata,
                                                     avsByteenable));
                default: ;
            endcase
        end
    end

    // R18: source from nibble when selection enabled, else the default input
    assign liveSource = ctrl_reg[CTRL_SELECT_ENABLE] ? source_reg : {1'b0, DEFAULT_INPUT};
    // R11: once running only the latched source counts
    assign activeSource = (state_reg == IPP_IDLE) ? liveSource : latchSource_reg;

    // R21: two-stage synchroniser on every interrupt input
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqMeta_reg <= '0;
            irqSync_reg <= '0;
        end else begin
            irqMeta_reg <= interruptInput;
            irqSync_reg <= irqMeta_reg;
        end
    end

    always_comb begin
        selectedRaw = 1'b0;
        if (activeSource == SRC_SOFT) begin
            selectedRaw = ctrl_reg[CTRL_SOFT_TRIGGER];
        end else if (activeSource <= SRC_LAST_INPUT) begin
            selectedRaw = irqSync_reg[activeSource[2:0]];
        end
    end

    // R03: inversion selects active-low sense; R04: bypassed for soft trigger
    assign irqLevel = (activeSource == SRC_SOFT) ? selectedRaw
                                                 : (selectedRaw ^ ctrl_reg[CTRL_IRQ_INVERT]);
    // R21: act on the asserting edge after polarity
    assign irqEdge = irqLevel && !irqLevelPrev_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqLevelPrev_reg <= 1'b0;
        end else begin
            irqLevelPrev_reg <= irqLevel;
        end
    end

    // R17: the chosen input is reserved while the channel is busy
    generate
        for (genvar g = 0; g < NUM_INPUTS; g++) begin : gen_claim
            assign irqClaim[g] = busy && (activeSource == 4'(g));
        end
    endgenerate

    assign startCmd = ctrl_reg[CTRL_START];
    assign startRise = startCmd && !startPrev_reg;
    assign sourceBad = (liveSource > SRC_SOFT) && (liveSource != SRC_UNUSED);
    assign busy = (state_reg != IPP_IDLE);
    assign absCount = count_reg[31] ? (32'h0000_0000 - count_reg) : count_reg;
    // R16: only the limit lying in the current travel direction stops us
    assign limitHit = dir_reg ? ctrl_reg[CTRL_FWD_LIMIT] : ctrl_reg[CTRL_REV_LIMIT];
    // R08: highest frequency that can still ramp down inside the remaining count
    assign fitFreq = 48'(remaining_reg) * 48'(latchStep_reg[15:0] == 16'h0000 ? latchTarget_reg
                                                                               : latchStep_reg);
    assign nextStop = (curFreq_reg > latchStep_reg) ? (curFreq_reg - latchStep_reg) : 32'h0000_0000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            startPrev_reg <= 1'b0;
        end else begin
            startPrev_reg <= startCmd;
        end
    end

    // Start, refusal and error flags
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            opError_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else if (startRise) begin
            // R14: a new start while busy is refused
            refused_reg <= busy || (liveSource == SRC_UNUSED);
            // R19: reserved nibbles raise an operation error
            opError_reg <= !busy && sourceBad;
        end
    end

    // Main sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= IPP_IDLE;
            latchSource_reg <= RESET_SOURCE;
            latchTarget_reg <= 32'h0000_0000;
            latchStep_reg <= 32'h0000_0000;
            remaining_reg <= 32'h0000_0000;
            pulseTotal_reg <= 33'h0_0000_0000;
            curFreq_reg <= 32'h0000_0000;
            dir_reg <= 1'b0;
            abortAbnormal_reg <= 1'b0;
            complete_reg <= 1'b0;
            abnormal_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                IPP_IDLE: begin
                    // R19: no motion on a bad or unused source, or a zero move
                    if (startRise && !sourceBad && liveSource != SRC_UNUSED
                            && absCount != 32'h0000_0000 && freq_reg != 32'h0000_0000) begin
                        // R11: operands frozen for the whole move
                        latchSource_reg <= liveSource;
                        latchTarget_reg <= freq_reg;
                        latchStep_reg <= rampStepOf(ramp_reg, freq_reg);
                        remaining_reg <= absCount;
                        pulseTotal_reg <= 33'h0_0000_0000;
                        // R05: direction from the sign of the count
                        dir_reg <= !count_reg[31];
                        curFreq_reg <= (rampStepOf(ramp_reg, freq_reg) < freq_reg)
                                       ? rampStepOf(ramp_reg, freq_reg) : freq_reg;
                        abortAbnormal_reg <= 1'b0;
                        complete_reg <= 1'b0;
                        abnormal_reg <= 1'b0;
                        // R10: interrupt already present counts down at once
                        state_reg <= irqLevel ? IPP_POSIT : IPP_RUN;
                    end
                end
                IPP_RUN: begin
                    if (!startCmd || limitHit) begin
                        // R12: start dropped; R16: limit in travel direction
                        abortAbnormal_reg <= startCmd;
                        state_reg <= IPP_STOP;
                    // R06: interrupt starts the post-interrupt count
                    // R01: soft trigger source acts the same way
                    end else if (irqEdge) begin
                        state_reg <= IPP_POSIT;
                    end else if (tick) begin
                        pulseTotal_reg <= pulseTotal_reg + 33'h0_0000_0001;
                        if (curFreq_reg < latchTarget_reg) begin
                            curFreq_reg <= (latchTarget_reg - curFreq_reg > latchStep_reg)
                                           ? curFreq_reg + latchStep_reg : latchTarget_reg;
                        end
                        // R13: overflow without interrupt ends the move as complete
                        if (pulseTotal_reg + 33'h0_0000_0001 == PULSE_OVERFLOW) begin
                            complete_reg <= 1'b1;
                            state_reg <= IPP_IDLE;
                        end
                    end
                end
                IPP_POSIT: begin
                    if (!startCmd || limitHit) begin
                        abortAbnormal_reg <= startCmd;
                        state_reg <= IPP_STOP;
                    end else if (tick) begin
                        remaining_reg <= remaining_reg - 32'h0000_0001;
                        // R06: stop once the count has gone out; R07: flag it
                        if (remaining_reg == 32'h0000_0001) begin
                            complete_reg <= 1'b1;
                            state_reg <= IPP_IDLE;
                        // R08: cap the speed so the ramp down fits the rest
                        end else if (fitFreq - 48'(latchStep_reg) < 48'(curFreq_reg)) begin
                            curFreq_reg <= (nextStop == 32'h0000_0000) ? curFreq_reg : nextStop;
                        end else if (curFreq_reg < latchTarget_reg) begin
                            curFreq_reg <= (latchTarget_reg - curFreq_reg > latchStep_reg)
                                           ? curFreq_reg + latchStep_reg : latchTarget_reg;
                        end
                    end
                end
                IPP_STOP: begin
                    // R12: deceleration stop leaves complete clear
                    if (tick) begin
                        if (nextStop == 32'h0000_0000) begin
                            // R16: abnormal end reported once stopped
                            abnormal_reg <= abortAbnormal_reg;
                            state_reg <= IPP_IDLE;
                        end else begin
                            curFreq_reg <= nextStop;
                        end
                    end
                end
            endcase
        end
    end

    // R20: position follows every emitted pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            position_reg <= 32'h0000_0000;
        end else if (tick && busy) begin
            position_reg <= dir_reg ? position_reg + 32'h0000_0001 : position_reg - 32'h0000_0001;
        end
    end

    assign directionOutput = dir_reg;

    ipp_rate_gen #(
        .FREQ_WIDTH(32)
    ) u_rate_gen (
        .clk(clk),
        .resetn(resetn),
        .enable(busy),
        .freq(curFreq_reg),
        .pulseOut(pulseOutput),
        .tick(tick)
    );

endmodule : ipp_positioner

// ---- ipp_drive_model.sv ----
/*
 * Motor drive stand-in: counts step pulses and keeps a signed position.
 * Assumes one step per rising edge of step, dirFwd high for forward.
 */
module ipp_drive_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic step,
    input wire logic dirFwd,
    output int pulses,
    output int position
);
    timeunit 1ns;
    timeprecision 1ns;
    logic stepLast;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stepLast <= 1'b0;
            pulses <= 0;
            position <= 0;
        end else begin
            stepLast <= step;
            if (step && !stepLast) begin
                pulses <= pulses + 1;
                position <= dirFwd ? position + 1 : position - 1;
            end
        end
    end
endmodule : ipp_drive_model

// ---- ipp_positioner_properties.sv ----
/*
 * Port-level checks for the pulse channel.
 * Assumes binding to ipp_positioner on its single clock domain.
 */
module ipp_positioner_properties
    import ipp_pkg::*;
#(
    parameter int NUM_INPUTS = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [4:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic avsWaitrequest,
    input wire logic [NUM_INPUTS-1:0] irqClaim,
    input wire logic pulseOutput,
    input wire logic directionOutput,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic startWr;
    assign startWr = avsWrite && !avsWaitrequest && avsAddress == ADDR_CTRL && avsWritedata[CTRL_START];
    property p_wait_one;
        (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("access held beyond one wait cycle");
    property p_idle_nowait;
        !(avsRead || avsWrite) |-> !avsWaitrequest;
    endproperty
    a_idle_nowait: assert property (p_idle_nowait)
        else $error("waitrequest raised with no access");
    property p_claim_idle;
        !busy |-> irqClaim == '0;
    endproperty
    a_claim_idle: assert property (p_claim_idle)
        else $error("input claimed while idle");
    property p_claim_one;
        busy |-> $onehot0(irqClaim);
    endproperty
    a_claim_one: assert property (p_claim_one)
        else $error("more than one input claimed");
    property p_pulse_busy;
        $rose(pulseOutput) |-> $past(busy);
    endproperty
    a_pulse_busy: assert property (p_pulse_busy)
        else $error("pulse outside motion");
    property p_dir_settled;
        $rose(pulseOutput) |-> $stable(directionOutput);
    endproperty
    a_dir_settled: assert property (p_dir_settled)
        else $error("direction moved at a pulse edge");
    property p_dir_hold;
        busy && $past(busy) |-> $stable(directionOutput);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direction changed during motion");
    property p_start_cause;
        $rose(busy) |-> $past(startWr, 1) || $past(startWr, 2) || $past(startWr, 3) || $past(startWr, 4);
    endproperty
    a_start_cause: assert property (p_start_cause)
        else $error("motion began without a start write");
endmodule : ipp_positioner_properties

bind ipp_positioner ipp_positioner_properties #(.NUM_INPUTS(NUM_INPUTS)) u_props (
    .clk(clk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsWaitrequest(avsWaitrequest), .irqClaim(irqClaim),
    .pulseOutput(pulseOutput), .directionOutput(directionOutput), .busy(busy));

// ---- interrupt_positioning_pulser_test.sv ----
/*
 * Self-checking bench for the pulse channel: Avalon master, drive model, read scoreboard.
 * Assumes 10 MHz clock and a 100 kHz test rate, so one pulse spans 100 cycles.
 */
module interrupt_positioning_pulser_test;
    import ipp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} ipp_note_t;
    logic clk, resetn, avsRead, avsWrite, avsWaitrequest, pulseOutput, directionOutput, busy;
    logic [4:0] avsAddress;
    logic [31:0] avsWritedata, avsReaddata;
    logic [7:0] interruptInput, irqClaim;
    logic [3:0] bad [2];
    int drvPulses, drvPosition, fails, samplesChecked, cycles, base, n;
    ipp_note_t notes [$];
    ipp_note_t note;
    always #50 clk = ~clk;
    ipp_positioner u_dut (.clk(clk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(4'hF), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .interruptInput(interruptInput), .pulseOutput(pulseOutput),
        .directionOutput(directionOutput), .irqClaim(irqClaim), .busy(busy));
    ipp_drive_model u_drive (.clk(clk), .resetn(resetn), .step(pulseOutput), .dirFwd(directionOutput),
        .pulses(drvPulses), .position(drvPosition));
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task finish_test;
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // Request held until waitrequest is seen low at an edge
    task bus(input logic [4:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= d;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask : bus
    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr
    task rd(input string name, input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{name, e, m});
        bus(a, 1'b0, 32'h0000_0000);
    endtask : rd
    task wait_pulses(input int target);
        for (int i = 0; i < 20000 && drvPulses < target; i++) @(posedge clk);
    endtask : wait_pulses
    task wait_idle;
        repeat (5) @(posedge clk);
        for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge clk);
    endtask : wait_idle
    // Waits a pulse edge so the count base is not split by a pulse in flight
    task mark;
        @(posedge pulseOutput);
        repeat (2) @(posedge clk);
        base = drvPulses;
    endtask : mark
    task endrun(input logic [31:0] e, input logic [31:0] m);
        wait_idle();
        rd("status", ADDR_STATUS, e, m);
        rd("position", ADDR_POSITION, 32'(drvPosition), 32'hFFFF_FFFF);
        // trigger and start cleared after idle
        wr(ADDR_CTRL, 32'h0000_0000);
        interruptInput <= 8'h00;
        $display("run done");
    endtask : endrun
    always @(posedge clk) begin
        if (avsRead && avsWaitrequest === 1'b0) begin
            note = notes.pop_front();
            check(note.name, avsReaddata & note.mask, note.exp);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        clk = 0;
        resetn = 0;
        avsAddress = 0;
        avsRead = 0;
        avsWrite = 0;
        avsWritedata = 0;
        interruptInput = 0;
        void'($urandom(82517));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd("ctrl", ADDR_CTRL, RESET_CTRL, 32'hFFFF_FFFF);
        rd("freq", ADDR_FREQ, RESET_FREQ, 32'hFFFF_FFFF);
        rd("count", ADDR_COUNT, RESET_COUNT, 32'hFFFF_FFFF);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        rd("status", ADDR_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
        rd("unmapped", 5'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
        $display("reset test done");
        n = 2 + $urandom % 4;
        wr(ADDR_FREQ, 32'h0001_86A0);
        wr(ADDR_COUNT, 32'(n));
        wr(ADDR_CTRL, 32'h0000_0001);
        wait_pulses(2 + $urandom % 3);
        wr(ADDR_COUNT, 32'h0000_0040);
        mark();
        interruptInput[0] <= 1'b1;
        wait_idle();
        check("irq pulses", 32'(drvPulses - base), 32'(n));
        endrun(32'h0000_0022, 32'h0000_0027);
        wr(ADDR_SOURCE, 32'h0000_0003);
        wr(ADDR_CTRL, 32'h0000_000C);
        wr(ADDR_COUNT, 32'hFFFF_FFFD);
        base = drvPulses;
        wr(ADDR_CTRL, 32'h0000_000D);
        repeat (5) @(posedge clk);
        check("claim", {24'h00_0000, irqClaim}, 32'h0000_0008);
        wait_idle();
        check("plain move", 32'(drvPulses - base), 32'h0000_0003);
        endrun(32'h0000_0002, 32'h0000_0027);
        interruptInput <= 8'($urandom);
        wr(ADDR_SOURCE, {28'h000_0000, SRC_SOFT});
        wr(ADDR_COUNT, 32'h0000_0004);
        wr(ADDR_CTRL, 32'h0000_000D);
        wait_pulses(drvPulses + 6);
        check("awaiting trigger", {31'h0000_0000, busy}, 32'h0000_0001);
        mark();
        wr(ADDR_CTRL, 32'h0000_000F);
        wait_idle();
        check("soft pulses", 32'(drvPulses - base), 32'h0000_0004);
        endrun(32'h0000_0022, 32'h0000_0027);
        bad[0] = 4'h9 + 4'($urandom % 6);
        bad[1] = SRC_UNUSED;
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_SOURCE, {28'h000_0000, bad[i]});
            wr(ADDR_CTRL, 32'h0000_0009);
            repeat (20) @(posedge clk);
            check("no motion", {31'h0000_0000, busy}, 32'h0000_0000);
            rd("bad source", ADDR_STATUS, i == 0 ? 32'h0000_0008 : 32'h0000_0010, 32'h0000_0019);
            wr(ADDR_CTRL, 32'h0000_0000);
        end
        wr(ADDR_SOURCE, 32'h0000_0000);
        wr(ADDR_COUNT, 32'h0000_000A);
        wr(ADDR_CTRL, 32'h0000_0001);
        wait_pulses(drvPulses + 2);
        wr(ADDR_CTRL, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0001);
        endrun(32'h0000_0010, 32'h0000_0017);
        wr(ADDR_CTRL, 32'h0000_0001);
        wait_pulses(drvPulses + 2);
        wr(ADDR_CTRL, 32'h0000_0011);
        endrun(32'h0000_0004, 32'h0000_0007);
        finish_test();
    end
endmodule : interrupt_positioning_pulser_test
